/* src/tmoc_pin_drv.sv */
// Pin stage: polarity and enable applied to the internal output level.
// Assumes inputs registered in the system clock domain.
`timescale 1ns/1ps
module tmoc_pin_drv (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  input wire logic invert_i,
  input wire logic enable_i,
  output logic pin_o,
  output logic pin_oe_o
);

  typedef struct packed {
    logic pin;
    logic oe;
  } tmoc_drv_st_t;

  tmoc_drv_st_t st_r;
  tmoc_drv_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.oe = enable_i;
    // Parked low when not driving so the idle value is defined
    st_nxt.pin = enable_i ? (level_i ^ invert_i) : 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_o = st_r.pin;
  assign pin_oe_o = st_r.oe;

endmodule : tmoc_pin_drv

/* src/tmoc_pkg.sv */
// Package for the timer mode and output control block.
// Assumes a single 20 MHz system clock and an 8-bit register port.
package tmoc_pkg;

  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // Register indices (word per index)
  localparam logic [1:0] ADDR_MODE_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;

  // Field positions in the mode and output control register
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int ACT_HI = 5;
  localparam int ACT_LO = 4;
  localparam int INIT_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int SWAP_BIT = 1;
  localparam int CLR_BIT = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register bit positions
  localparam int ST_PIN_BIT = 0;
  localparam int ST_LEVEL_BIT = 1;
  localparam int ST_UNDEF_BIT = 2;

  typedef enum logic [1:0] {
    MODE_CMP = 2'h0,
    MODE_UNDEF = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TMR = 2'h3
  } tmoc_mode_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } tmoc_act_t;

  typedef struct packed {
    tmoc_mode_t operating_mode_select;
    tmoc_act_t pin_action_select;
    logic output_initial_level;
    logic output_polarity_invert;
    logic period_duty_swap;
    logic counter_clear_select;
  } tmoc_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tmoc_bus_req_t;

endpackage : tmoc_pkg

/* src/tmoc_top.sv */
// Mode select and output-pin control for a compact 10-bit timer.
// Assumes compare match and PWM waveform come from the counter logic
// as one-cycle pulse and level synchronous to clk_sys_i.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module tmoc_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [tmoc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [tmoc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic counter_on_control_i,
  input wire logic cmp_a_match_i,
  input wire logic pwm_wave_i,
  output logic [tmoc_pkg::DATA_W-1:0] reg_rdata_o,
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe_o,
  output logic period_duty_swap_o,
  output logic counter_clear_select_o
);

  typedef struct packed {
    tmoc_pkg::tmoc_ctrl_t ctrl;
    logic level;
    logic on_prev;
    logic [tmoc_pkg::DATA_W-1:0] rdata;
  } tmoc_st_t;

  logic [1:0] rst_sync_r;
  logic rst_n;
  tmoc_st_t st_r;
  tmoc_st_t st_nxt;
  tmoc_pkg::tmoc_bus_req_t req;
  logic drive_en;
  logic inv_en;

  // Release reset through two flops; assert stays asynchronous
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign req.addr = reg_addr_i;
  assign req.wdata = reg_wdata_i;
  assign req.wr = reg_wr_i;
  assign req.rd = reg_rd_i;

  always_comb begin
    st_nxt = st_r;
    st_nxt.on_prev = counter_on_control_i;
    st_nxt.rdata = '0;
    if (req.wr && req.addr == tmoc_pkg::ADDR_MODE_CTRL) begin
      st_nxt.ctrl = tmoc_pkg::tmoc_ctrl_t'(req.wdata);
    end
    // Output level uses the settings in force before this cycle's write
    case (st_r.ctrl.operating_mode_select)
      tmoc_pkg::MODE_CMP: begin
        if (counter_on_control_i && !st_r.on_prev) begin
          st_nxt.level = st_r.ctrl.output_initial_level;
        end else if (cmp_a_match_i) begin
          case (st_r.ctrl.pin_action_select)
            tmoc_pkg::ACT_LOW: st_nxt.level = 1'b0;
            tmoc_pkg::ACT_HIGH: st_nxt.level = 1'b1;
            tmoc_pkg::ACT_TOGGLE: st_nxt.level = ~st_r.level;
            default: st_nxt.level = st_r.level;
          endcase
        end
      end
      tmoc_pkg::MODE_PWM: begin
        // Active level picked by the initial-level bit
        case (st_r.ctrl.pin_action_select)
          tmoc_pkg::ACT_NONE: st_nxt.level = ~st_r.ctrl.output_initial_level;
          tmoc_pkg::ACT_LOW: st_nxt.level = st_r.ctrl.output_initial_level;
          tmoc_pkg::ACT_HIGH: st_nxt.level = ~(pwm_wave_i ^ st_r.ctrl.output_initial_level);
          default: st_nxt.level = st_r.level;
        endcase
      end
      // Undefined and timer modes hold the level
      default: st_nxt.level = st_r.level;
    endcase
    if (req.rd) begin
      case (req.addr)
        tmoc_pkg::ADDR_MODE_CTRL: st_nxt.rdata = st_r.ctrl;
        tmoc_pkg::ADDR_STATUS: begin
          st_nxt.rdata[tmoc_pkg::ST_PIN_BIT] = timer_output_pin_o;
          st_nxt.rdata[tmoc_pkg::ST_LEVEL_BIT] = st_r.level;
          st_nxt.rdata[tmoc_pkg::ST_UNDEF_BIT] =
            (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_UNDEF);
        end
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r.ctrl <= tmoc_pkg::tmoc_ctrl_t'(tmoc_pkg::CTRL_RESET);
      st_r.level <= 1'b0;
      st_r.on_prev <= 1'b0;
      st_r.rdata <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin is released in timer mode and undefined mode
  assign drive_en = (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_CMP) ||
                    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_PWM);
  assign inv_en = st_r.ctrl.output_polarity_invert;

  tmoc_pin_drv u_pin_drv (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .level_i(st_r.level),
    .invert_i(inv_en),
    .enable_i(drive_en),
    .pin_o(timer_output_pin_o),
    .pin_oe_o(timer_output_pin_oe_o)
  );

  assign reg_rdata_o = st_r.rdata;
  assign period_duty_swap_o = st_r.ctrl.period_duty_swap;
  assign counter_clear_select_o = st_r.ctrl.counter_clear_select;

  property p_cmp_set_high;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_CMP && cmp_a_match_i &&
     st_r.ctrl.pin_action_select == tmoc_pkg::ACT_HIGH &&
     !(counter_on_control_i && !st_r.on_prev)) |=> st_r.level;
  endproperty
  a_cmp_set_high: assert property (p_cmp_set_high) else $error("match high failed");

  property p_cmp_toggle;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_CMP && cmp_a_match_i &&
     st_r.ctrl.pin_action_select == tmoc_pkg::ACT_TOGGLE &&
     !(counter_on_control_i && !st_r.on_prev)) |=> (st_r.level != $past(st_r.level));
  endproperty
  a_cmp_toggle: assert property (p_cmp_toggle) else $error("toggle failed");

  property p_no_match_hold;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_CMP && !cmp_a_match_i &&
     !(counter_on_control_i && !st_r.on_prev)) |=> $stable(st_r.level);
  endproperty
  a_no_match_hold: assert property (p_no_match_hold) else $error("level moved");

  property p_on_restore;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_CMP && counter_on_control_i &&
     !st_r.on_prev) |=> (st_r.level == $past(st_r.ctrl.output_initial_level));
  endproperty
  a_on_restore: assert property (p_on_restore) else $error("restore failed");

  property p_tmr_released;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_TMR) |=> !timer_output_pin_oe_o;
  endproperty
  a_tmr_released: assert property (p_tmr_released) else $error("pin driven");

  property p_pwm_active;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_PWM &&
     st_r.ctrl.pin_action_select == tmoc_pkg::ACT_LOW)
    |=> (st_r.level == $past(st_r.ctrl.output_initial_level));
  endproperty
  a_pwm_active: assert property (p_pwm_active) else $error("force active failed");

  property p_pwm_wave;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_PWM &&
     st_r.ctrl.pin_action_select == tmoc_pkg::ACT_HIGH && st_r.ctrl.output_initial_level)
    |=> (st_r.level == $past(pwm_wave_i));
  endproperty
  a_pwm_wave: assert property (p_pwm_wave) else $error("waveform failed");

  property p_polarity;
    @(posedge clk_sys_i) disable iff (!rst_n)
    drive_en |=> (timer_output_pin_o == ($past(st_r.level) ^ $past(inv_en)));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");

  property p_read_ctrl;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (reg_rd_i && reg_addr_i == tmoc_pkg::ADDR_MODE_CTRL && !$past(reg_wr_i))
    |=> (reg_rdata_o == $past(st_r.ctrl));
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("read data wrong");

  property p_cmp_set_low;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_CMP && cmp_a_match_i &&
     st_r.ctrl.pin_action_select == tmoc_pkg::ACT_LOW &&
     !(counter_on_control_i && !st_r.on_prev)) |=> !st_r.level;
  endproperty
  a_cmp_set_low: assert property (p_cmp_set_low) else $error("match low failed");

  property p_cmp_no_change;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_CMP && cmp_a_match_i &&
     st_r.ctrl.pin_action_select == tmoc_pkg::ACT_NONE &&
     !(counter_on_control_i && !st_r.on_prev)) |=> $stable(st_r.level);
  endproperty
  a_cmp_no_change: assert property (p_cmp_no_change) else $error("match moved level");

  property p_pwm_inactive;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_PWM &&
     st_r.ctrl.pin_action_select == tmoc_pkg::ACT_NONE)
    |=> (st_r.level == !$past(st_r.ctrl.output_initial_level));
  endproperty
  a_pwm_inactive: assert property (p_pwm_inactive) else $error("inactive failed");

  property p_pwm_undef_hold;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_PWM &&
     st_r.ctrl.pin_action_select == tmoc_pkg::ACT_TOGGLE) |=> $stable(st_r.level);
  endproperty
  a_pwm_undef_hold: assert property (p_pwm_undef_hold) else $error("pwm level moved");

  property p_pwm_wave_low;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_PWM &&
     st_r.ctrl.pin_action_select == tmoc_pkg::ACT_HIGH && !st_r.ctrl.output_initial_level)
    |=> (st_r.level == !$past(pwm_wave_i));
  endproperty
  a_pwm_wave_low: assert property (p_pwm_wave_low) else $error("low wave failed");

  // Undefined mode released so a stray write cannot drive the line
  property p_undef_released;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_UNDEF) |=> !timer_output_pin_oe_o;
  endproperty
  a_undef_released: assert property (p_undef_released) else $error("undef drives");

  property p_driven;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_CMP ||
     st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_PWM) |=> timer_output_pin_oe_o;
  endproperty
  a_driven: assert property (p_driven) else $error("pin not driven");

  // Parked low so a released pin never shows the polarity bit
  property p_parked;
    @(posedge clk_sys_i) disable iff (!rst_n)
    !drive_en |=> !timer_output_pin_o;
  endproperty
  a_parked: assert property (p_parked) else $error("parked pin high");

  property p_idle_hold;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_TMR ||
     st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_UNDEF) |=> $stable(st_r.level);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle level moved");

  property p_ctrl_write;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (reg_wr_i && reg_addr_i == tmoc_pkg::ADDR_MODE_CTRL)
    |=> (st_r.ctrl == tmoc_pkg::tmoc_ctrl_t'($past(reg_wdata_i)));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("write lost");

  property p_read_undef;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (reg_rd_i && reg_addr_i == tmoc_pkg::ADDR_STATUS) |=>
    (reg_rdata_o[tmoc_pkg::ST_UNDEF_BIT] ==
     ($past(st_r.ctrl.operating_mode_select) == tmoc_pkg::MODE_UNDEF));
  endproperty
  a_read_undef: assert property (p_read_undef) else $error("undef flag wrong");

  property p_read_pin;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (reg_rd_i && reg_addr_i == tmoc_pkg::ADDR_STATUS) |=>
    (reg_rdata_o[tmoc_pkg::ST_PIN_BIT] == $past(timer_output_pin_o));
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("pin flag wrong");

  c_toggle: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    cmp_a_match_i && st_r.ctrl.pin_action_select == tmoc_pkg::ACT_TOGGLE);
  c_pwm: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_PWM && pwm_wave_i);
  c_restore: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    counter_on_control_i && !st_r.on_prev);
  c_undef: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    st_r.ctrl.operating_mode_select == tmoc_pkg::MODE_UNDEF);
  c_restore_match: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    counter_on_control_i && !st_r.on_prev && cmp_a_match_i);

endmodule : tmoc_top

/* test/tmoc_pin_load.sv */
// Load on the timer output pin: the line seen by outside circuitry.
// Assumes a pull-down on the line while the block leaves it undriven.
`timescale 1ns/1ps
module tmoc_pin_load (
  input wire logic pin_i,
  input wire logic oe_i,
  output logic line_o
);
  // Pull-down wins when undriven, so a stale level cannot pass
  assign line_o = oe_i ? pin_i : 1'b0;
endmodule : tmoc_pin_load

/* test/tmoc_top_bench.sv */
// Self-checking bench for the timer mode and output control block.
// Assumes the pin load model; counter logic inputs come from the tasks.
`timescale 1ns/1ps
module tmoc_top_bench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, on = 1'b0, match = 1'b0, wave = 1'b0;
  logic [7:0] rdata, got;
  logic pin, oe, swap, clr, line;
  int n_errors = 0, checks_done = 0, cycles = 0;
  logic [1:0] modes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic oes [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  always #25 clk_sys_i = ~clk_sys_i;
  tmoc_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .counter_on_control_i(on),
    .cmp_a_match_i(match), .pwm_wave_i(wave), .reg_rdata_o(rdata),
    .timer_output_pin_o(pin), .timer_output_pin_oe_o(oe),
    .period_duty_swap_o(swap), .counter_clear_select_o(clr));
  tmoc_pin_load load (.pin_i(pin), .oe_i(oe), .line_o(line));
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // Ceiling well above the roughly 230 cycles the scenarios take
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk1(string name, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", name, e, g);
    end
  endtask : chk1
  task automatic chk8(string name, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk8
  task automatic wr_reg(logic [1:0] a, logic [7:0] d);
    @(posedge clk_sys_i) begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
    end
    @(posedge clk_sys_i) wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [1:0] a);
    @(posedge clk_sys_i) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk_sys_i) rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg
  // Margin over the two-edge pin pipe plus the control register edge
  task automatic settle();
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask : settle
  task automatic pin_is(logic eo, logic el);
    chk1("pin_oe", eo, oe);
    chk1("pin_line", el, line);
  endtask : pin_is
  task automatic pulse();
    @(posedge clk_sys_i) match <= 1'b1;
    @(posedge clk_sys_i) match <= 1'b0;
    settle();
  endtask : pulse
  task automatic restart(logic [7:0] d);
    @(posedge clk_sys_i) on <= 1'b0;
    wr_reg(tmoc_pkg::ADDR_MODE_CTRL, d);
    @(posedge clk_sys_i) on <= 1'b1;
    settle();
  endtask : restart
  task automatic t_regs();
    rd_reg(tmoc_pkg::ADDR_MODE_CTRL);
    chk8("ctrl_reset", tmoc_pkg::CTRL_RESET, got);
    settle();
    pin_is(1'b1, 1'b0);
    wr_reg(2'h2, 8'hFF);
    rd_reg(2'h2);
    chk8("unmapped", 8'h00, got);
    wr_reg(tmoc_pkg::ADDR_MODE_CTRL, 8'hAB);
    rd_reg(tmoc_pkg::ADDR_MODE_CTRL);
    chk8("ctrl_back", 8'hAB, got);
    chk1("swap", 1'b1, swap);
    chk1("clear_sel", 1'b1, clr);
  endtask : t_regs
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      restart({modes[i], 6'h00});
      chk1("mode_oe", oes[i], oe);
    end
    restart(8'hF4);
    pin_is(1'b0, 1'b0);
  endtask : t_modes
  task automatic t_cmp();
    restart(8'h20);
    pin_is(1'b1, 1'b0);
    settle();
    pin_is(1'b1, 1'b0);
    pulse();
    pin_is(1'b1, 1'b1);
    wr_reg(tmoc_pkg::ADDR_MODE_CTRL, 8'h00);
    pulse();
    pin_is(1'b1, 1'b1);
    wr_reg(tmoc_pkg::ADDR_MODE_CTRL, 8'h10);
    pulse();
    pin_is(1'b1, 1'b0);
    wr_reg(tmoc_pkg::ADDR_MODE_CTRL, 8'h34);
    pulse();
    pin_is(1'b1, 1'b0);
    pulse();
    pin_is(1'b1, 1'b1);
    // Restart and match together: restart must win
    @(posedge clk_sys_i) on <= 1'b0;
    @(posedge clk_sys_i) begin
      on <= 1'b1;
      match <= 1'b1;
    end
    @(posedge clk_sys_i) match <= 1'b0;
    settle();
    pin_is(1'b1, 1'b1);
    restart(8'h08);
    pin_is(1'b1, 1'b1);
  endtask : t_cmp
  task automatic t_pwm();
    restart(8'hA8);
    @(posedge clk_sys_i) wave <= 1'b1;
    settle();
    pin_is(1'b1, 1'b1);
    restart(8'hA0);
    pin_is(1'b1, 1'b0);
    restart(8'hAC);
    pin_is(1'b1, 1'b0);
    restart(8'h88);
    pin_is(1'b1, 1'b0);
    @(posedge clk_sys_i) wave <= 1'b0;
    restart(8'h98);
    pin_is(1'b1, 1'b1);
  endtask : t_pwm
  task automatic t_status();
    rd_reg(tmoc_pkg::ADDR_STATUS);
    chk8("status_pwm", 8'h03, got);
    @(posedge clk_sys_i) #1;
    chk8("rdata_idle", 8'h00, rdata);
    restart(8'h88);
    @(posedge clk_sys_i) wave <= 1'b1;
    restart(8'hB8);
    pin_is(1'b1, 1'b0);
    restart(8'hF4);
    rd_reg(tmoc_pkg::ADDR_STATUS);
    chk8("status_timer", 8'h00, got);
    restart(8'h43);
    rd_reg(tmoc_pkg::ADDR_STATUS);
    chk8("status_undef", 8'h04, got);
    chk1("swap_set", 1'b1, swap);
    chk1("clear_set", 1'b1, clr);
  endtask : t_status
  task automatic t_reset();
    @(posedge clk_sys_i) rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd_reg(tmoc_pkg::ADDR_MODE_CTRL);
    chk8("ctrl_rerun", tmoc_pkg::CTRL_RESET, got);
    chk1("swap_rerun", 1'b0, swap);
    chk1("clear_rerun", 1'b0, clr);
    settle();
    pin_is(1'b1, 1'b0);
  endtask : t_reset
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_regs();
    t_modes();
    t_cmp();
    t_pwm();
    t_status();
    t_reset();
    close_out();
  end
endmodule : tmoc_top_bench
